/* verif/charger_mode_input_limit_regs_test.sv */
/*
 * Self-checking bench for the charger command registers over SMBus.
 * Assumes the host model file and the bound checker are compiled first.
 */
`timescale 1ns/1ps

`define CHECK(got, exp) \
    begin \
        samples_checked++; \
        if ((got) !== (exp)) begin \
            fail_count++; \
            $display("Error at %0t: got %h expected %h", $time, (got), (exp)); \
        end \
    end

module charger_mode_input_limit_regs_test
    import charger_regs_pkg::*;
;
    localparam logic [6:0] DEV_ID = 7'h09;  // bus address, arbitrary
    logic        clock, rst_n, smb_scl, sda_low, smb_sda_out, smb_sda_oe, irq_n, ok;
    logic        supply_loss, pack_present, adapter_detected, adapter_above_cells;
    logic        overtemp_latched_event, source_gate_system, source_gate_load, alarm_clear;
    logic        charge_block_ff, overtemp_latched, charge_enable, alarm_seen;
    logic [15:0] input_limit_ma, charge_amps_code, charge_volts_code;
    logic [7:0]  rd;
    wire         smb_sda_in;
    int          fail_count = 0;
    int          samples_checked = 0;
    logic [15:0] raw_tab [8] = '{16'h0080, 16'h0180, 16'h1F80, 16'hFFFF,
                                 16'h0001, 16'h0000, 16'h2AFC, 16'h2AFD};
    logic [15:0] exp_tab [8] = '{16'h0100, 16'h0100, 16'h1F00, 16'h2AFC,
                                 16'h0100, 16'h0000, 16'h0A00, 16'h2AFC};

    // open-drain line with pull-up
    assign smb_sda_in = !(sda_low || smb_sda_oe);

    charger_mode_input_limit_regs #(.DEV_ADDR(DEV_ID)) charger_mode_input_limit_regs_inst (.*);
    smbus_host_model smbus_host_model_inst (.clock, .sda_wire(smb_sda_in), .smb_scl, .sda_low);

    // sticky flag for any alarm clear pulse after reset
    always @(posedge clock) alarm_seen <= rst_n && (alarm_seen || alarm_clear);

    // 50 mhz clock
    initial begin
        clock = 1'b0;
        forever #10 clock = ~clock;
    end

    task automatic tick(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask

    task automatic wr(input logic [7:0] cmd, input logic [15:0] data);
        smbus_host_model_inst.write_word(DEV_ID, cmd, data, ok);
        `CHECK(ok, 1'b1)
    endtask

    task automatic flip(input int k);
        case (k)
            0: adapter_detected = !adapter_detected;
            1: pack_present = !pack_present;
            default: supply_loss = !supply_loss;
        endcase
        tick(8);
    endtask

    task automatic hot_pulse();
        overtemp_latched_event = 1'b1;
        tick(8);
        overtemp_latched_event = 1'b0;
        tick(8);
    endtask

    task automatic end_test(input string name);
        $display("test %s finished, %0d checks so far", name, samples_checked);
    endtask

    task automatic test_done();
        $display("checks %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // tests take about 8.4k cycles; allow about six times that
    initial begin
        #1000000;
        fail_count++;
        $display("Error at %0t: watchdog expired", $time);
        test_done();
    end

    // main sequence
    initial begin
        rst_n = 1'b0;
        {supply_loss, pack_present, adapter_detected} = 3'b000;
        {adapter_above_cells, overtemp_latched_event} = 2'b00;
        tick(6);
        rst_n = 1'b1;
        tick(6);
        `CHECK(input_limit_ma, ILIM_MIN_MA)
        `CHECK({charge_amps_code, charge_volts_code}, {AMPS_POR, VOLTS_POR})
        `CHECK({charge_block_ff, overtemp_latched, charge_enable, irq_n}, 4'h3)
        end_test("reset");
        hot_pulse();
        `CHECK({overtemp_latched, charge_enable}, 2'b10)
        wr(CMD_MODE_WORD, 16'h0004);
        `CHECK({overtemp_latched, charge_enable, alarm_seen}, 3'b011)
        end_test("hot_default");
        for (int i = 0; i < 8; i++) begin
            wr(CMD_INPUT_LIMIT, raw_tab[i]);
            `CHECK(input_limit_ma, exp_tab[i])
        end
        end_test("input_limit");
        wr(CMD_CHARGE_AMPS, 16'h0400);
        wr(CMD_CHARGE_VOLT, 16'h3000);
        wr(CMD_MODE_WORD, 16'h0001);
        `CHECK({charge_block_ff, charge_enable}, 2'b10)
        wr(CMD_MODE_WORD, 16'h0004);
        `CHECK({charge_block_ff, charge_amps_code, charge_volts_code}, {1'b0, AMPS_POR, VOLTS_POR})
        wr(CMD_MODE_WORD, 16'h0009);
        `CHECK({charge_amps_code, charge_volts_code}, {ZERO_WORD, ZERO_WORD})
        wr(CMD_MODE_WORD, 16'hFA82);
        `CHECK({charge_block_ff, charge_enable, charge_amps_code}, {2'b01, ZERO_WORD})
        hot_pulse();
        `CHECK({overtemp_latched, charge_enable}, 2'b11)
        end_test("mode_word");
        wr(CMD_MODE_WORD, 16'h0000);
        adapter_above_cells = 1'b1;
        tick(8);
        `CHECK({source_gate_system, source_gate_load}, 2'b01)
        wr(CMD_MODE_WORD, 16'h0100);
        `CHECK({source_gate_system, source_gate_load}, 2'b10)
        adapter_above_cells = 1'b0;
        end_test("source_select");
        for (int k = 0; k < 3; k++) begin
            wr(CMD_MODE_WORD, 16'h0000);
            flip(k);
            `CHECK(irq_n, 1'b0)
            smbus_host_model_inst.alert_read(ok, rd);
            `CHECK({ok, rd, irq_n, smb_sda_out}, {1'b1, DEV_ID, 1'b0, 2'b10})
            wr(CMD_MODE_WORD, 16'h0010 << k);
            flip(k);
            `CHECK(irq_n, 1'b1)
        end
        `CHECK({input_limit_ma, charge_amps_code}, {ILIM_MIN_MA, AMPS_POR})
        `CHECK(overtemp_latched, 1'b0)
        end_test("interrupts");
        smbus_host_model_inst.write_word(7'h0A, CMD_INPUT_LIMIT, 16'h1F80, ok);
        `CHECK(ok, 1'b0)
        wr(8'h3E, 16'h1F80);
        `CHECK(input_limit_ma, ILIM_MIN_MA)
        end_test("refusals");
        test_done();
    end
endmodule

/* verif/charger_regs_sva.sv */
/*
 * Checker for the charger command registers.
 * Assumes it is bound to the top module and sees only its ports.
 */
`timescale 1ns/1ps

module charger_regs_sva
    import charger_regs_pkg::*;
(
    input wire logic        clock,
    input wire logic        rst_n,
    input wire logic        supply_loss,
    input wire logic        pack_present,
    input wire logic        adapter_detected,
    input wire logic        adapter_above_cells,
    input wire logic        overtemp_latched_event,
    input wire logic        smb_sda_oe,
    input wire logic        irq_n,
    input wire logic        source_gate_system,
    input wire logic        source_gate_load,
    input wire logic [15:0] input_limit_ma,
    input wire logic [15:0] charge_amps_code,
    input wire logic [15:0] charge_volts_code,
    input wire logic        charge_block_ff,
    input wire logic        overtemp_latched,
    input wire logic        charge_enable,
    input wire logic        alarm_clear
);
    logic [2:0] sense_q;
    logic [3:0] quiet_q;

    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);

    // cycles since a status input last moved, saturating
    always_ff @(posedge clock) begin
        sense_q <= {supply_loss, pack_present, adapter_detected};
        if (!rst_n) begin
            quiet_q <= 4'hF;
        end else if (sense_q != {supply_loss, pack_present, adapter_detected}) begin
            quiet_q <= 4'h0;
        end else if (quiet_q != 4'hF) begin
            quiet_q <= quiet_q + 4'h1;
        end
    end

    // ----------
    // properties
    // ----------
    property p_por; disable iff (1'b0) !rst_n |=> input_limit_ma == ILIM_MIN_MA &&
        charge_amps_code == AMPS_POR && charge_volts_code == VOLTS_POR && irq_n; endproperty
    a_por: assert property (p_por) else $error("reset values wrong");
    property p_grid; (input_limit_ma[7:0] == 8'h00 && input_limit_ma < ILIM_MAX_MA) ||
        input_limit_ma == ILIM_MAX_MA; endproperty
    a_grid: assert property (p_grid) else $error("input limit off grid");
    property p_block_stops; charge_block_ff |=> !charge_enable; endproperty
    a_block_stops: assert property (p_block_stops) else $error("inhibit left on");
    property p_free_runs; !charge_block_ff && !overtemp_latched |=> charge_enable; endproperty
    a_free_runs: assert property (p_free_runs) else $error("charger held off");
    property p_source_excl; source_gate_system != source_gate_load; endproperty
    a_source_excl: assert property (p_source_excl) else $error("gates both on");
    property p_cells_low; (!adapter_above_cells)[*6] |=> source_gate_system && !source_gate_load;
    endproperty
    a_cells_low: assert property (p_cells_low) else $error("adapter fed when low");
    property p_hot_sets; overtemp_latched_event[*6] |=> overtemp_latched; endproperty
    a_hot_sets: assert property (p_hot_sets) else $error("hot latch not set");
    property p_pack_gone; pack_present ##1 (!pack_present)[*6] |=>
        input_limit_ma == ILIM_MIN_MA && charge_amps_code == AMPS_POR; endproperty
    a_pack_gone: assert property (p_pack_gone) else $error("removal kept limit");
    property p_alarm_pulse; alarm_clear |=> !alarm_clear; endproperty
    a_alarm_pulse: assert property (p_alarm_pulse) else $error("alarm clear too long");
    property p_irq_cause; $fell(irq_n) |-> quiet_q < 4'h8; endproperty
    a_irq_cause: assert property (p_irq_cause) else $error("irq without change");
    property p_irq_release; $rose(irq_n) |-> $fell(smb_sda_oe); endproperty
    a_irq_release: assert property (p_irq_release) else $error("irq freed early");
endmodule

bind charger_mode_input_limit_regs charger_regs_sva charger_regs_sva_inst (.*);

/* verif/smbus_host_model.sv */
/*
 * Behavioural SMBus host: write-word frames and alert response reads.
 * Assumes sda_wire is the resolved open-drain line with a pull-up.
 */
`timescale 1ns/1ps

module smbus_host_model
    import charger_regs_pkg::*;
#(
    parameter int HALF = 4      // clocks per scl phase
) (
    input  wire logic clock,
    input  wire logic sda_wire,
    output logic      smb_scl,
    output logic      sda_low
);
    // bus idle: both lines released
    initial begin
        smb_scl = 1'b1;
        sda_low = 1'b0;
    end

    // wait clocks, then step just past the edge
    task automatic tick(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask

    // start or repeated start, scl left low
    task automatic start_bit();
        tick(HALF / 2);
        sda_low = 1'b0;
        tick(HALF / 2);
        smb_scl = 1'b1;
        tick(HALF);
        sda_low = 1'b1;
        tick(HALF);
        smb_scl = 1'b0;
    endtask

    // stop leaves the bus released
    task automatic stop_bit();
        tick(HALF / 2);
        sda_low = 1'b1;
        tick(HALF / 2);
        smb_scl = 1'b1;
        tick(HALF);
        sda_low = 1'b0;
        tick(HALF);
    endtask

    // data set mid-low, sampled at end of high
    task automatic clock_bit(input logic b, output logic s);
        tick(HALF / 2);
        sda_low = !b;
        tick(HALF / 2);
        smb_scl = 1'b1;
        tick(HALF);
        s = sda_wire;
        smb_scl = 1'b0;
    endtask

    // eight bits msb first, then the acknowledge slot
    task automatic xfer_byte(input logic [7:0] d, input logic ack_in,
                             output logic [7:0] q, output logic ack_out);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            clock_bit(d[i], q[i]);
        end
        clock_bit(!ack_in, s);
        ack_out = !s;
    endtask

    // address, command, low byte then high byte
    task automatic write_word(input logic [6:0] addr, input logic [7:0] cmd,
                              input logic [15:0] data, output logic ok);
        logic [7:0] q;
        logic       a0, a1, a2, a3;
        start_bit();
        xfer_byte({addr, 1'b0}, 1'b0, q, a0);
        xfer_byte(cmd, 1'b0, q, a1);
        xfer_byte(data[7:0], 1'b0, q, a2);
        xfer_byte(data[15:8], 1'b0, q, a3);
        stop_bit();
        ok = a0 & a1 & a2 & a3;
    endtask

    // alert response read, last byte not acked
    task automatic alert_read(output logic ok, output logic [7:0] d);
        logic [7:0] q;
        start_bit();
        xfer_byte({ALERT_ADDR, 1'b1}, 1'b0, q, ok);
        xfer_byte(8'hFF, 1'b0, d, q[0]);
        stop_bit();
    endtask
endmodule

/* verilog/charger_mode_input_limit_regs.sv */
/*
 * Write-only charger command registers behind an SMBus slave: the
 * input current limit, the mode word and the charge settings that the
 * mode word acts on, plus the interrupt line and source selection.
 * Assumes SCL/SDA and all sense inputs are asynchronous to clock;
 * SDA is open drain, resolved outside from smb_sda_oe.
 */
`timescale 1ns/1ps

// Contract
// RULE_01 - command 0x3F writes input limit word
// RULE_02 - ignore bits 0-6 and 13-15
// RULE_03 - input limit quantised to 256 ma
// RULE_04 - requests above 11.004 a clamp there
// RULE_05 - requests of 1-256 ma give 256
// RULE_06 - input limit resets to 0x0080
// RULE_07 - pack removal restores input limit default
// RULE_08 - command 0x12 writes mode word
// RULE_09 - bit 0 sets or clears inhibit flop
// RULE_10 - bit 2 restores charge defaults, clears latches
// RULE_11 - bit 3 zeroes charge current and voltage
// RULE_12 - bits 4-6 mask status change interrupts
// RULE_13 - bit 8 low: adapter feeds when above cells
// RULE_14 - bit 8 high: battery always feeds system
// RULE_15 - bit 10 defaults high, hot halts charging
// RULE_16 - hot latch cleared by defaults or removal
// RULE_17 - mode bits 0,2-6,8 zero_settings_bit
// RULE_18 - interrupt request drives line low
// RULE_19 - loss, pack, adapter changes raise interrupt
// RULE_20 - status inputs mean loss, pack, adapter
// RULE_21 - unimplemented mode bits accepted, no effect
// RULE_22 - interrupt held until alert response read
module charger_mode_input_limit_regs
    import charger_regs_pkg::*;
#(
    parameter logic [6:0] DEV_ADDR = 7'h09      // bus address, arbitrary default
) (
    input  wire logic        clock,
    input  wire logic        rst_n,
    input  wire logic        smb_scl,
    input  wire logic        smb_sda_in,
    output logic             smb_sda_out,
    output logic             smb_sda_oe,
    input  wire logic        supply_loss,
    input  wire logic        pack_present,
    input  wire logic        adapter_detected,
    input  wire logic        adapter_above_cells,
    input  wire logic        overtemp_latched_event,
    output logic             irq_n,
    output logic             source_gate_system,
    output logic             source_gate_load,
    output logic [15:0]      input_limit_ma,
    output logic [15:0]      charge_amps_code,
    output logic [15:0]      charge_volts_code,
    output logic             charge_block_ff,
    output logic             overtemp_latched,
    output logic             charge_enable,
    output logic             alarm_clear
);

    // ----------------------------------------------------------------
    // elaboration check
    // ----------------------------------------------------------------
    if (DEV_ADDR == ALERT_ADDR) begin : g_bad_addr
        $error("device address collides with alert response address");
    end

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [2:0]          scl_sy;
        logic [2:0]          sda_sy;
        logic [SENSE_W-1:0]  sn_s1;
        logic [SENSE_W-1:0]  sn_s2;
        logic [SENSE_W-1:0]  sn_s3;
        logic [SENSE_W-1:0]  sn;
        logic                scl;
        logic                sda;
        link_st_t            st;
        logic [3:0]          bit_cnt;
        logic [7:0]          shift;
        logic [7:0]          cmd;
        logic [7:0]          lo;
        logic                ack;
        logic                tx;
        logic                sda_drv;
        logic [15:0]         ilim_raw;
        logic [15:0]         ilim_eff;
        logic [15:0]         mode;
        logic [15:0]         amps;
        logic [15:0]         volts;
        logic                inhibit;
        logic                hot;
        logic                irq;
        logic                alarm_clr;
        logic                gate_sys;
        logic                gate_load;
        logic                chg_en;
    } state_t;

    state_t s_q;
    state_t s_d;

    logic        scl_rise;
    logic        scl_fall;
    logic        start_cond;
    logic        stop_cond;
    logic        scl_new;
    logic        sda_new;
    logic [15:0] word;
    logic [15:0] masked;
    logic [SENSE_W-1:0] sn_new;
    logic        pack_gone;
    logic        status_change;

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    always_comb begin
        s_d = s_q;

        // three-stage sampling; a change counts once stages 2 and 3 agree
        s_d.scl_sy = {s_q.scl_sy[1:0], smb_scl};
        s_d.sda_sy = {s_q.sda_sy[1:0], smb_sda_in};
        s_d.sn_s1  = {overtemp_latched_event, adapter_above_cells, adapter_detected,
                      pack_present, supply_loss};
        s_d.sn_s2  = s_q.sn_s1;
        s_d.sn_s3  = s_q.sn_s2;
        scl_new = (s_q.scl_sy[1] == s_q.scl_sy[2]) ? s_q.scl_sy[2] : s_q.scl;
        sda_new = (s_q.sda_sy[1] == s_q.sda_sy[2]) ? s_q.sda_sy[2] : s_q.sda;
        for (int i = 0; i < SENSE_W; i++) begin
            sn_new[i] = (s_q.sn_s2[i] == s_q.sn_s3[i]) ? s_q.sn_s3[i] : s_q.sn[i];
        end
        s_d.scl = scl_new;
        s_d.sda = sda_new;
        s_d.sn  = sn_new;

        scl_rise   = !s_q.scl && scl_new;
        scl_fall   = s_q.scl && !scl_new;
        start_cond = s_q.scl && scl_new && s_q.sda && !sda_new;
        stop_cond  = s_q.scl && scl_new && !s_q.sda && sda_new;
        word       = {s_q.shift, s_q.lo};
        s_d.alarm_clr = 1'b0;

        // serial link: receive on rising scl, drive sda after falling scl
        if (start_cond || stop_cond) begin
            s_d.st      = start_cond ? S_ADDR : S_IDLE;
            s_d.bit_cnt = 4'h0;
            s_d.ack     = 1'b0;
            s_d.tx      = 1'b0;
            s_d.sda_drv = 1'b0;
        end else if (scl_rise && !s_q.tx && !s_q.ack && s_q.bit_cnt < BYTE_BITS) begin
            s_d.shift   = {s_q.shift[6:0], sda_new};
            s_d.bit_cnt = s_q.bit_cnt + ONE_BIT;
        end else if (scl_fall && s_q.ack) begin
            // end of acknowledge slot
            s_d.ack     = 1'b0;
            s_d.sda_drv = 1'b0;
            s_d.bit_cnt = 4'h0;
            if (s_q.st == S_TX) begin
                s_d.tx      = 1'b1;
                s_d.sda_drv = ~DEV_ADDR[6];
                s_d.shift   = {DEV_ADDR[5:0], 2'b00};
                s_d.bit_cnt = ONE_BIT;
            end
        end else if (scl_fall && s_q.tx) begin
            if (s_q.bit_cnt < BYTE_BITS) begin
                s_d.sda_drv = ~s_q.shift[7];
                s_d.shift   = {s_q.shift[6:0], 1'b0};
                s_d.bit_cnt = s_q.bit_cnt + ONE_BIT;
            end else begin
                // address handed over: line released
                s_d.sda_drv = 1'b0;
                s_d.tx      = 1'b0;
                s_d.irq     = 1'b0;                                    // RULE_22
                s_d.st      = S_SKIP;
            end
        end else if (scl_fall && s_q.bit_cnt == BYTE_BITS) begin
            // whole byte in: decide on acknowledge and next step
            s_d.ack     = 1'b1;
            s_d.sda_drv = 1'b1;
            case (s_q.st)
                S_ADDR: begin
                    if (s_q.shift == {DEV_ADDR, 1'b0}) begin
                        s_d.st = S_CMD;
                    end else if (s_q.shift == {ALERT_ADDR, 1'b1} && s_q.irq) begin
                        s_d.st = S_TX;                                 // RULE_22
                    end else begin
                        s_d.ack     = 1'b0;
                        s_d.sda_drv = 1'b0;
                        s_d.st      = S_SKIP;
                    end
                end
                S_CMD: begin
                    s_d.cmd = s_q.shift;
                    s_d.st  = S_DLO;
                end
                S_DLO: begin
                    s_d.lo = s_q.shift;
                    s_d.st = S_DHI;
                end
                S_DHI: begin
                    s_d.st = S_SKIP;
                    case (s_q.cmd)
                        CMD_INPUT_LIMIT: s_d.ilim_raw = word;          // RULE_01
                        CMD_CHARGE_AMPS: s_d.amps = word;
                        CMD_CHARGE_VOLT: s_d.volts = word;
                        CMD_MODE_WORD: begin                           // RULE_08
                            s_d.mode    = word & MODE_IMPL_MASK;       // RULE_21
                            s_d.inhibit = word[MB_INHIBIT];            // RULE_09
                            if (word[MB_DEFAULTS]) begin               // RULE_10
                                s_d.volts     = VOLTS_POR;
                                s_d.amps      = AMPS_POR;
                                s_d.hot       = 1'b0;                  // RULE_16
                                s_d.alarm_clr = 1'b1;
                            end
                            if (word[MB_ZERO]) begin                   // RULE_11
                                s_d.amps  = ZERO_WORD;
                                s_d.volts = ZERO_WORD;
                            end
                        end
                        default: s_d.st = S_SKIP;
                    endcase
                end
                default: begin
                    s_d.ack     = 1'b0;
                    s_d.sda_drv = 1'b0;
                end
            endcase
        end

        // pack removal restores the limit and charge settings and clears the hot latch
        pack_gone = s_q.sn[SN_PACK] && !sn_new[SN_PACK];
        if (pack_gone) begin
            s_d.ilim_raw          = ILIM_POR;                          // RULE_07
            s_d.amps              = AMPS_POR;
            s_d.volts             = VOLTS_POR;
            s_d.hot               = 1'b0;                              // RULE_16
            s_d.alarm_clr         = 1'b1;
            s_d.mode[MB_HOT_HALT] = 1'b1;
        end

        // hot latch: the set wins over any clear in the same cycle
        if (sn_new[SN_HOT_EVENT]) begin
            s_d.hot = 1'b1;
        end

        // status edges raise the request unless masked; set beats clear
        status_change =
            ((s_q.sn[SN_ADAPTER] ^ sn_new[SN_ADAPTER]) && !s_q.mode[MB_MASK_ADAPTER]) ||
            ((s_q.sn[SN_PACK] ^ sn_new[SN_PACK]) && !s_q.mode[MB_MASK_PACK]) ||
            ((s_q.sn[SN_LOSS] ^ sn_new[SN_LOSS]) && !s_q.mode[MB_MASK_LOSS]); // RULE_12 RULE_19 RULE_20
        if (status_change) begin
            s_d.irq = 1'b1;
        end

        // effective input limit from the stored word
        masked = s_q.ilim_raw & ILIM_KEEP_MASK;                        // RULE_02
        if (s_q.ilim_raw > ILIM_MAX_MA) begin
            s_d.ilim_eff = ILIM_MAX_MA;                                // RULE_04
        end else if (masked < ILIM_MIN_MA && s_q.ilim_raw != ZERO_WORD) begin
            s_d.ilim_eff = ILIM_MIN_MA;                                // RULE_05
        end else begin
            s_d.ilim_eff = masked & ILIM_STEP_MASK;                    // RULE_03
        end

        // source selection: p-channel gates, low means conducting
        if (s_q.sn[SN_ABOVE_CELLS] && !s_q.mode[MB_RELEARN]) begin     // RULE_13
            s_d.gate_sys  = 1'b0;
            s_d.gate_load = 1'b1;
        end else begin                                                 // RULE_14
            s_d.gate_sys  = 1'b1;
            s_d.gate_load = 1'b0;
        end

        // charger runs unless inhibited or halted by the hot latch
        s_d.chg_en = !s_q.inhibit && !(s_q.hot && s_q.mode[MB_HOT_HALT]); // RULE_15

        // synchronous reset
        if (!rst_n) begin
            s_d          = '0;
            s_d.scl_sy   = 3'h7;
            s_d.sda_sy   = 3'h7;
            s_d.scl      = 1'b1;
            s_d.sda      = 1'b1;
            s_d.st       = S_IDLE;
            s_d.ilim_raw = ILIM_POR;                                   // RULE_06
            s_d.ilim_eff = ILIM_MIN_MA;
            s_d.mode     = MODE_POR;                                   // RULE_17
            s_d.amps     = AMPS_POR;
            s_d.volts    = VOLTS_POR;
            s_d.gate_sys = 1'b1;
            s_d.chg_en   = 1'b1;
        end
    end

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    always_ff @(posedge clock) begin
        s_q <= s_d;
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    assign smb_sda_out        = 1'b0;            // open drain: only pulls low
    assign smb_sda_oe         = s_q.sda_drv;
    assign irq_n              = ~s_q.irq;        // RULE_18
    assign source_gate_system = s_q.gate_sys;
    assign source_gate_load   = s_q.gate_load;
    assign input_limit_ma     = s_q.ilim_eff;
    assign charge_amps_code   = s_q.amps;
    assign charge_volts_code  = s_q.volts;
    assign charge_block_ff    = s_q.inhibit;
    assign overtemp_latched   = s_q.hot;
    assign charge_enable      = s_q.chg_en;
    assign alarm_clear        = s_q.alarm_clr;

endmodule

/* verilog/charger_regs_pkg.sv */
/*
 * Constants for the charger mode and input-limit command registers:
 * command codes, reset values, field masks, mode bit positions and
 * the layout of the synchronised sense inputs.
 * Assumes an SMBus host that uses Write-Word transactions and alert response reads.
 */
package charger_regs_pkg;

    // ----------------------------------------------------------------
    // command codes
    // ----------------------------------------------------------------
    localparam logic [7:0]  CMD_INPUT_LIMIT = 8'h3F;
    localparam logic [7:0]  CMD_MODE_WORD   = 8'h12;
    localparam logic [7:0]  CMD_CHARGE_AMPS = 8'h14;
    localparam logic [7:0]  CMD_CHARGE_VOLT = 8'h15;

    // ----------------------------------------------------------------
    // reset values and input-limit arithmetic
    // ----------------------------------------------------------------
    localparam logic [15:0] ILIM_POR        = 16'h0080;
    localparam logic [15:0] AMPS_POR        = 16'h0080;
    localparam logic [15:0] VOLTS_POR       = 16'h4B00;
    localparam logic [15:0] ZERO_WORD       = 16'h0000;
    localparam logic [15:0] ILIM_KEEP_MASK  = 16'h1F80;   // drops d0-d6, d13-d15
    localparam logic [15:0] ILIM_STEP_MASK  = 16'h1F00;   // 256 ma steps
    localparam logic [15:0] ILIM_MIN_MA     = 16'h0100;   // 256 ma
    localparam logic [15:0] ILIM_MAX_MA     = 16'h2AFC;   // 11004 ma

    // ----------------------------------------------------------------
    // mode word layout
    // ----------------------------------------------------------------
    localparam logic [15:0] MODE_IMPL_MASK  = 16'h057D;
    localparam logic [15:0] MODE_POR        = 16'h0400;
    localparam int          MB_INHIBIT      = 0;
    localparam int          MB_DEFAULTS     = 2;
    localparam int          MB_ZERO         = 3;
    localparam int          MB_MASK_ADAPTER = 4;
    localparam int          MB_MASK_PACK    = 5;
    localparam int          MB_MASK_LOSS    = 6;
    localparam int          MB_RELEARN      = 8;
    localparam int          MB_HOT_HALT     = 10;

    // ----------------------------------------------------------------
    // sense vector layout and serial link constants
    // ----------------------------------------------------------------
    localparam int          SENSE_W         = 5;
    localparam int          SN_LOSS         = 0;
    localparam int          SN_PACK         = 1;
    localparam int          SN_ADAPTER      = 2;
    localparam int          SN_ABOVE_CELLS  = 3;
    localparam int          SN_HOT_EVENT    = 4;
    localparam logic [6:0]  ALERT_ADDR      = 7'h0C;
    localparam logic [3:0]  BYTE_BITS       = 4'h8;
    localparam logic [3:0]  ONE_BIT         = 4'h1;

    typedef enum logic [2:0] {
        S_IDLE = 3'b000,
        S_ADDR = 3'b001,
        S_CMD  = 3'b010,
        S_DLO  = 3'b011,
        S_DHI  = 3'b100,
        S_TX   = 3'b101,
        S_SKIP = 3'b110
    } link_st_t;

endpackage
